// ===== src/legacy_decode_pkg.sv
/*
 * Constants for the legacy serial/parallel port positive decoder:
 * register indices and byte addresses, reset values, field layout,
 * and the table of legacy I/O ranges with the port that owns each.
 * Assumes a 16-bit primary I/O address and a 10-bit Avalon byte address.
 */
package legacy_decode_pkg;

    // Port count and range count
    localparam int NUM_PORTS  = 7;
    localparam int NUM_RANGES = 10;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] ENABLES_IDX = 8'h68;
    localparam logic [7:0] MAP_IDX     = 8'h6A;
    localparam logic [7:0] STATUS_IDX  = 8'h80;

    localparam logic [9:0] ENABLES_ADDR = {ENABLES_IDX, 2'h0};
    localparam logic [9:0] MAP_ADDR     = {MAP_IDX, 2'h0};
    localparam logic [9:0] STATUS_ADDR  = {STATUS_IDX, 2'h0};

    // Reset values and field layout
    localparam logic [6:0]  ENABLES_RST = 7'h00;
    localparam logic [6:0]  MAP_RST     = 7'h00;
    localparam logic [15:0] REG_WIDE_RST = 16'h0000;
    localparam int          PORT_LSB    = 0;
    localparam int          PORT_MSB    = 6;
    localparam int          STAT_CLAIM  = 8;

    // Port bit positions
    localparam int SERIAL_PORT_A   = 0;
    localparam int SERIAL_PORT_B   = 1;
    localparam int SERIAL_PORT_C   = 2;
    localparam int SERIAL_PORT_D   = 3;
    localparam int PARALLEL_PORT_A = 4;
    localparam int PARALLEL_PORT_B = 5;
    localparam int PARALLEL_PORT_C = 6;

    // Range table, inclusive bounds
    localparam logic [15:0] RANGE_LO [NUM_RANGES] = '{
        16'h03F8, 16'h02F8, 16'h03E8, 16'h02E8, 16'h03BC,
        16'h07BC, 16'h0378, 16'h0778, 16'h0278, 16'h0678};
    localparam logic [15:0] RANGE_HI [NUM_RANGES] = '{
        16'h03FF, 16'h02FF, 16'h03EF, 16'h02EF, 16'h03BF,
        16'h07BF, 16'h037F, 16'h077B, 16'h027F, 16'h067B};

    // Which ranges belong to each port, bit r set for range r
    localparam logic [NUM_RANGES-1:0] OWNER_MASK [NUM_PORTS] = '{
        10'h001, 10'h002, 10'h004, 10'h008,
        10'h030, 10'h0C0, 10'h300};

    // Bus slave handshake
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage : legacy_decode_pkg

// ===== src/io_range_match.sv
/*
 * Inclusive range comparator for one legacy I/O range.
 * Assumes the address is stable for the cycle it is compared in.
 */
`timescale 1ns/100ps
module io_range_match #(
    parameter logic [15:0] LO = 16'h0000,
    parameter logic [15:0] HI = 16'h0000
) (
    input  wire logic [15:0] addr,
    output wire logic        hit
);

    // Pure compare, no storage
    assign hit = (addr >= LO) && (addr <= HI);

endmodule : io_range_match

// ===== src/legacy_io_port_positive_decode.sv
/*
 * Legacy serial and parallel port positive decode for a bridge primary
 * interface, with its two control registers on an Avalon-MM slave.
 * Assumes IO_CYCLE, IO_ADDR and IO_WINDOW_HIT come from the primary bus
 * logic on MCLK, and that the Avalon master holds its request until it
 * sees waitrequest low.
 */
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
// Overview of operation
// R1 - Enable bit 0 decodes 3F8h-3FFh, serial A
// R2 - Enable bit 1 decodes 2F8h-2FFh, serial B
// R3 - Enable bit 2 decodes 3E8h-3EFh, serial C
// R4 - Enable bit 3 decodes 2E8h-2EFh, serial D
// R5 - Enable bit 4 decodes 3BCh-3BFh, 7BCh-7BFh
// R6 - Enable bit 5 decodes 378h-37Fh, 778h-77Bh
// R7 - Enable bit 6 decodes 278h-27Fh, 678h-67Bh
// R8 - Map bit one includes, zero excludes range
// R9 - Covering enabled I/O window still claims
// R10 - Map register at 6Ah, resets to zero
// R11 - Map bits: 6-4 parallel, 3-0 serial
// R12 - Enable register at 68h, resets to zero
// R13 - Bits 15 to 7 read zero, ignore writes
module legacy_io_port_positive_decode (
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        IO_CYCLE,
    input  wire logic [15:0] IO_ADDR,
    input  wire logic        IO_WINDOW_HIT,
    output logic             IO_CLAIM,
    output logic      [6:0]  IO_PORT_HIT
);

    // Register state
    legacy_decode_pkg::bus_state_t state_q;
    legacy_decode_pkg::bus_state_t state_d;
    logic [6:0]  enables_q;
    logic [6:0]  enables_d;
    logic [6:0]  map_q;
    logic [6:0]  map_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        wait_q;
    logic        wait_d;
    logic        claim_q;
    logic        claim_d;
    logic [6:0]  port_hit_q;
    logic [6:0]  port_hit_d;
    logic [7:0]  last_q;
    logic [7:0]  last_d;

    // Decode nets
    wire logic [legacy_decode_pkg::NUM_RANGES-1:0] range_hit;
    wire logic [legacy_decode_pkg::NUM_PORTS-1:0]  port_in;
    wire logic [6:0] decoded;
    wire logic [6:0] included;

    // Bus nets
    wire logic        req;
    wire logic        take;
    wire logic        wr_fire;
    wire logic        sel_enables;
    wire logic        sel_map;
    wire logic        sel_status;
    wire logic [31:0] rd_word;

    // One comparator per legacy range
    genvar r;
    generate
        for (r = 0; r < legacy_decode_pkg::NUM_RANGES; r++) begin : g_range
            io_range_match #(
                .LO (legacy_decode_pkg::RANGE_LO[r]),
                .HI (legacy_decode_pkg::RANGE_HI[r])
            ) u_match (
                .addr (IO_ADDR),
                .hit  (range_hit[r])
            );
        end
    endgenerate

    // Fold ranges onto their owning port
    genvar p;
    generate
        for (p = 0; p < legacy_decode_pkg::NUM_PORTS; p++) begin : g_port
            assign port_in[p] = |(range_hit & legacy_decode_pkg::OWNER_MASK[p]); // R11
        end
    endgenerate

    // Enable gates the decode, map decides primary inclusion
    assign decoded  = port_in & enables_q; // R1 R2 R3 R4 R5 R6 R7
    assign included = decoded & map_q; // R8 R11

    // Window hit claims even when the port is excluded by its map bit
    assign claim_d    = IO_CYCLE & ((|included) | IO_WINDOW_HIT); // R8 R9
    assign port_hit_d = IO_CYCLE ? decoded : 7'h00;
    assign last_d     = IO_CYCLE ? {claim_d, decoded} : last_q;

    // Address decode of the register slave
    assign req         = AVS_READ | AVS_WRITE;
    assign take        = req & (state_q == legacy_decode_pkg::BUS_IDLE);
    assign wr_fire     = AVS_WRITE & (state_q == legacy_decode_pkg::BUS_ACK);
    assign sel_enables = AVS_ADDRESS == legacy_decode_pkg::ENABLES_ADDR; // R12
    assign sel_map     = AVS_ADDRESS == legacy_decode_pkg::MAP_ADDR; // R10
    assign sel_status  = AVS_ADDRESS == legacy_decode_pkg::STATUS_ADDR;

    // Upper bits are absent; unmapped addresses read zero
    assign rd_word = sel_enables ? {25'h0000000, enables_q} : // R13
                     sel_map     ? {25'h0000000, map_q} :
                     sel_status  ? {23'h000000, last_q[7], 1'h0, last_q[6:0]} :
                                   32'h00000000;

    // One wait cycle, answer on the second edge
    assign state_d = take ? legacy_decode_pkg::BUS_ACK : legacy_decode_pkg::BUS_IDLE;
    assign wait_d  = ~take;
    assign rdata_d = take ? rd_word : rdata_q;

    // Only lane 0 holds bits; lane 1 writes are dropped
    assign enables_d = (wr_fire & sel_enables & AVS_BYTEENABLE[0]) ?
                       AVS_WRITEDATA[legacy_decode_pkg::PORT_MSB:legacy_decode_pkg::PORT_LSB] :
                       enables_q; // R12 R13
    assign map_d     = (wr_fire & sel_map & AVS_BYTEENABLE[0]) ?
                       AVS_WRITEDATA[legacy_decode_pkg::PORT_MSB:legacy_decode_pkg::PORT_LSB] :
                       map_q; // R10 R13

    // Bus handshake flops
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= legacy_decode_pkg::BUS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // Control registers, all ports excluded after reset
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            enables_q <= legacy_decode_pkg::ENABLES_RST; // R12
            map_q     <= legacy_decode_pkg::MAP_RST; // R10
        end else begin
            enables_q <= enables_d;
            map_q     <= map_d;
        end
    end

    // Registered claim keeps the outputs glitch free for the bus logic
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            claim_q    <= 1'b0;
            port_hit_q <= 7'h00;
            last_q     <= 8'h00;
        end else begin
            claim_q    <= claim_d;
            port_hit_q <= port_hit_d;
            last_q     <= last_d;
        end
    end

    // Outputs straight from flops
    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign IO_CLAIM        = claim_q;
    assign IO_PORT_HIT     = port_hit_q;

    // Serial port A decode and claim
    a_serial_a_claim: assert property (@(posedge MCLK) disable iff (!RSTN) // R1
        IO_CYCLE && IO_ADDR >= legacy_decode_pkg::RANGE_LO[0]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[0] && enables_q[0] && map_q[0]
        |=> IO_CLAIM && IO_PORT_HIT[legacy_decode_pkg::SERIAL_PORT_A])
        else $error("serial port A range not claimed");

    // Serial port B decode
    a_serial_b_hit: assert property (@(posedge MCLK) disable iff (!RSTN) // R2
        IO_CYCLE && IO_ADDR >= legacy_decode_pkg::RANGE_LO[1]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[1]
        |=> IO_PORT_HIT[legacy_decode_pkg::SERIAL_PORT_B] == $past(enables_q[1]))
        else $error("serial port B hit wrong");

    // Serial port C decode
    a_serial_c_hit: assert property (@(posedge MCLK) disable iff (!RSTN) // R3
        IO_CYCLE && IO_ADDR >= legacy_decode_pkg::RANGE_LO[2]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[2]
        |=> IO_PORT_HIT[legacy_decode_pkg::SERIAL_PORT_C] == $past(enables_q[2]))
        else $error("serial port C hit wrong");

    // Serial port D decode
    a_serial_d_hit: assert property (@(posedge MCLK) disable iff (!RSTN) // R4
        IO_CYCLE && IO_ADDR >= legacy_decode_pkg::RANGE_LO[3]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[3]
        |=> IO_PORT_HIT[legacy_decode_pkg::SERIAL_PORT_D] == $past(enables_q[3]))
        else $error("serial port D hit wrong");

    // Parallel port A, upper alias range
    a_parallel_a_alias: assert property (@(posedge MCLK) disable iff (!RSTN) // R5
        IO_CYCLE && IO_ADDR >= legacy_decode_pkg::RANGE_LO[5]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[5] && enables_q[4]
        |=> IO_PORT_HIT == 7'h10)
        else $error("parallel port A alias not decoded");

    // Parallel port B, short upper range ends at 77Bh
    a_parallel_b_edge: assert property (@(posedge MCLK) disable iff (!RSTN) // R6
        IO_CYCLE && IO_ADDR == legacy_decode_pkg::RANGE_HI[7] + 16'h0001
        |=> !IO_PORT_HIT[legacy_decode_pkg::PARALLEL_PORT_B])
        else $error("parallel port B decoded past its range");

    // Parallel port C, both ranges
    a_parallel_c_hit: assert property (@(posedge MCLK) disable iff (!RSTN) // R7
        IO_CYCLE && ((IO_ADDR >= legacy_decode_pkg::RANGE_LO[8]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[8])
        || (IO_ADDR >= legacy_decode_pkg::RANGE_LO[9]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[9]))
        |=> IO_PORT_HIT[legacy_decode_pkg::PARALLEL_PORT_C] == $past(enables_q[6]))
        else $error("parallel port C hit wrong");

    // Excluded port with no window is not claimed
    a_map_exclude: assert property (@(posedge MCLK) disable iff (!RSTN) // R8 R11
        IO_CYCLE && !IO_WINDOW_HIT && ((port_in & enables_q & map_q) == 7'h00)
        |=> !IO_CLAIM)
        else $error("claim without included port or window");

    // Window claim overrides exclusion
    a_window_claim: assert property (@(posedge MCLK) disable iff (!RSTN) // R9
        IO_CYCLE && IO_WINDOW_HIT |=> IO_CLAIM)
        else $error("covered window access not claimed");

    // Map register written only through its own address
    a_map_write: assert property (@(posedge MCLK) disable iff (!RSTN) // R10
        $changed(map_q) |-> $past(AVS_WRITE && !AVS_WAITREQUEST
        && AVS_ADDRESS == legacy_decode_pkg::MAP_ADDR && AVS_BYTEENABLE[0]))
        else $error("map register changed without a write");

    // Enable register written only through its own address
    a_enables_write: assert property (@(posedge MCLK) disable iff (!RSTN) // R12
        $changed(enables_q) |-> $past(AVS_WRITE && !AVS_WAITREQUEST
        && AVS_ADDRESS == legacy_decode_pkg::ENABLES_ADDR))
        else $error("enable register changed without a write");

    // Reserved bits read back as zero
    a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RSTN) // R13
        $fell(AVS_WAITREQUEST) && $past(AVS_ADDRESS) != legacy_decode_pkg::STATUS_ADDR
        |-> AVS_READDATA[31:7] == 25'h0000000)
        else $error("reserved bits read nonzero");

    // Every request answered on the second edge, for one cycle
    a_bus_answer: assert property (@(posedge MCLK) disable iff (!RSTN)
        $rose(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer timing wrong");

    // Serial port A stays dark while its enable bit is clear
    a_serial_a_off: assert property (@(posedge MCLK) disable iff (!RSTN) // R1
        IO_CYCLE && !enables_q[legacy_decode_pkg::SERIAL_PORT_A]
        && IO_ADDR >= legacy_decode_pkg::RANGE_LO[0]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[0]
        |=> !IO_PORT_HIT[legacy_decode_pkg::SERIAL_PORT_A])
        else $error("disabled serial port A decoded");

    // Map bit clear and no window, so nothing may claim
    a_serial_a_excl: assert property (@(posedge MCLK) disable iff (!RSTN) // R8
        IO_CYCLE && !IO_WINDOW_HIT && !map_q[legacy_decode_pkg::SERIAL_PORT_A]
        && IO_ADDR >= legacy_decode_pkg::RANGE_LO[0]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[0]
        |=> !IO_CLAIM)
        else $error("excluded serial port A claimed");

    // Parallel port A, lower range
    a_parallel_a_low: assert property (@(posedge MCLK) disable iff (!RSTN) // R5
        IO_CYCLE && IO_ADDR >= legacy_decode_pkg::RANGE_LO[4]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[4]
        |=> IO_PORT_HIT[legacy_decode_pkg::PARALLEL_PORT_A] == $past(enables_q[4]))
        else $error("parallel port A hit wrong");

    // Parallel port B, both ranges
    a_parallel_b_hit: assert property (@(posedge MCLK) disable iff (!RSTN) // R6
        IO_CYCLE && ((IO_ADDR >= legacy_decode_pkg::RANGE_LO[6]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[6])
        || (IO_ADDR >= legacy_decode_pkg::RANGE_LO[7]
        && IO_ADDR <= legacy_decode_pkg::RANGE_HI[7]))
        |=> IO_PORT_HIT[legacy_decode_pkg::PARALLEL_PORT_B] == $past(enables_q[5]))
        else $error("parallel port B hit wrong");

    // Outputs drop back to zero between cycles
    a_idle_quiet: assert property (@(posedge MCLK) disable iff (!RSTN)
        !IO_CYCLE |=> IO_PORT_HIT == 7'h00 && !IO_CLAIM)
        else $error("decode output without an I/O cycle");

    // Enable register cleared on leaving reset
    a_enables_reset: assert property (@(posedge MCLK) disable iff (!RSTN) // R12
        $rose(RSTN) |-> enables_q == legacy_decode_pkg::ENABLES_RST)
        else $error("enable register not cleared by reset");

    // Map register cleared on leaving reset
    a_map_reset: assert property (@(posedge MCLK) disable iff (!RSTN) // R10
        $rose(RSTN) |-> map_q == legacy_decode_pkg::MAP_RST)
        else $error("map register not cleared by reset");

    // Enable register read returns its bits in the low lane only
    a_enables_read: assert property (@(posedge MCLK) disable iff (!RSTN) // R12 R13
        $fell(AVS_WAITREQUEST) && $past(AVS_READ)
        && $past(AVS_ADDRESS) == legacy_decode_pkg::ENABLES_ADDR
        |-> AVS_READDATA == {25'h0000000, $past(enables_q)})
        else $error("enable register read back wrong");

endmodule : legacy_io_port_positive_decode

// ===== sim/io_cycle_source.sv
/*
 * Primary bus model: turns a bench request into one registered I/O cycle.
 * Assumes requests are changed by the bench right after a rising edge.
 */
`timescale 1ns/100ps
module io_cycle_source (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic [15:0] req_addr,
    input  wire logic        req_win,
    output logic             io_cycle = 1'b0,
    output logic      [15:0] io_addr = 16'h0000,
    output logic             io_window_hit = 1'b0
);
    // Outside a cycle the lines flip, so a stale address never looks valid
    always_ff @(posedge clk) begin
        io_cycle      <= req;
        io_addr       <= req ? req_addr : ~io_addr;
        io_window_hit <= req ? req_win : ~io_window_hit;
    end
endmodule : io_cycle_source

// ===== sim/test_legacy_io_port_positive_decode.sv
/*
 * Self-checking bench for the legacy port decoder: register bus, decode.
 * Assumes a 40 MHz clock; the bus task waits for whatever answer time the slave takes.
 */
`timescale 1ns/100ps
module test_legacy_io_port_positive_decode;
    logic        MCLK = 1'b0;
    logic        RSTN = 1'b0;
    logic [9:0]  AVS_ADDRESS = 10'h000;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [3:0]  AVS_BYTEENABLE = 4'hF;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST;
    logic        IO_CYCLE;
    logic [15:0] IO_ADDR;
    logic        IO_WINDOW_HIT;
    logic        IO_CLAIM;
    logic [6:0]  IO_PORT_HIT;
    logic        req = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic        req_win = 1'b0;
    logic [31:0] lfsr = 32'h0000_5B5E;
    logic [31:0] q;
    logic [6:0]  en_m, map_m, eh;
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;
    int lo[10] = '{16'h03F8, 16'h02F8, 16'h03E8, 16'h02E8, 16'h03BC,
                   16'h07BC, 16'h0378, 16'h0778, 16'h0278, 16'h0678};
    int hi[10] = '{16'h03FF, 16'h02FF, 16'h03EF, 16'h02EF, 16'h03BF,
                   16'h07BF, 16'h037F, 16'h077B, 16'h027F, 16'h067B};
    int own[10] = '{0, 1, 2, 3, 4, 4, 5, 5, 6, 6};

    legacy_io_port_positive_decode u_legacy_io_port_positive_decode (
        .MCLK            (MCLK),
        .RSTN            (RSTN),
        .AVS_ADDRESS     (AVS_ADDRESS),
        .AVS_READ        (AVS_READ),
        .AVS_WRITE       (AVS_WRITE),
        .AVS_WRITEDATA   (AVS_WRITEDATA),
        .AVS_BYTEENABLE  (AVS_BYTEENABLE),
        .AVS_READDATA    (AVS_READDATA),
        .AVS_WAITREQUEST (AVS_WAITREQUEST),
        .IO_CYCLE        (IO_CYCLE),
        .IO_ADDR         (IO_ADDR),
        .IO_WINDOW_HIT   (IO_WINDOW_HIT),
        .IO_CLAIM        (IO_CLAIM),
        .IO_PORT_HIT     (IO_PORT_HIT)
    );
    io_cycle_source u_io_cycle_source (.clk(MCLK), .req(req), .req_addr(req_addr),
        .req_win(req_win), .io_cycle(IO_CYCLE), .io_addr(IO_ADDR),
        .io_window_hit(IO_WINDOW_HIT));

    // Clock and hang guard
    initial begin
        forever #12.5 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            complete_run();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One Avalon access; held until waitrequest is seen low at an edge
    // No local limit: a hung slave is caught by the cycle ceiling
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        @(posedge MCLK);
        AVS_ADDRESS    <= a;
        AVS_WRITEDATA  <= d;
        AVS_BYTEENABLE <= be;
        AVS_WRITE      <= w;
        AVS_READ       <= !w;
        do begin
            @(posedge MCLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
    endtask : bus

    // Model decode, then one I/O cycle checked in its answer cycle
    task automatic io(input logic [15:0] a, input logic w);
        eh = 7'h00;
        for (int r = 0; r < 10; r++) begin
            if (a >= lo[r] && a <= hi[r] && en_m[own[r]]) eh[own[r]] = 1'b1;
        end
        @(posedge MCLK);
        req      <= 1'b1;
        req_addr <= a;
        req_win  <= w;
        @(posedge MCLK);
        req <= 1'b0;
        @(posedge MCLK);
        @(negedge MCLK);
        check("port_hit", {25'h0, IO_PORT_HIT}, {25'h0, eh});
        check("claim", {31'h0, IO_CLAIM}, {31'h0, (|(eh & map_m)) | w});
        @(negedge MCLK);
        check("claim_gone", {31'h0, IO_CLAIM}, 32'h0000_0000);
    endtask : io

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // Main sequence: reset values, reserved bits, then decode sweep
    initial begin
        int pt[4];
        repeat (10) @(posedge MCLK);
        RSTN <= 1'b1;
        bus(1'b0, legacy_decode_pkg::ENABLES_ADDR, 32'h0, 4'hF, q);
        check("enables_rst", q, 32'h0000_0000);
        bus(1'b0, legacy_decode_pkg::MAP_ADDR, 32'h0, 4'hF, q);
        check("map_rst", q, 32'h0000_0000);
        bus(1'b1, legacy_decode_pkg::MAP_ADDR, 32'hFFFF_FFFF, 4'hF, q);
        bus(1'b1, legacy_decode_pkg::MAP_ADDR, 32'h0000_0000, 4'h0, q);
        bus(1'b0, legacy_decode_pkg::MAP_ADDR, 32'h0, 4'hF, q);
        check("map_ro", q, 32'h0000_007F);
        bus(1'b1, 10'h004, 32'hFFFF_FFFF, 4'hF, q);
        bus(1'b0, 10'h004, 32'h0, 4'hF, q);
        check("unmapped", q, 32'h0000_0000);
        for (int r = 0; r < 10; r++) begin
            pt = '{lo[r] - 1, lo[r], hi[r], hi[r] + 1};
            for (int k = 0; k < 8; k++) begin
                lfsr = lfsr_next(lfsr);
                en_m  = lfsr[6:0] | ((k < 4) ? (7'h01 << own[r]) : 7'h00);
                map_m = lfsr[13:7];
                bus(1'b1, legacy_decode_pkg::ENABLES_ADDR, {lfsr[31:7], en_m}, 4'hF, q);
                bus(1'b1, legacy_decode_pkg::MAP_ADDR, {lfsr[31:14], 7'h00, map_m}, 4'hF, q);
                bus(1'b0, legacy_decode_pkg::ENABLES_ADDR, 32'h0, 4'hF, q);
                check("enables_rd", q, {25'h0, en_m});
                io(pt[k % 4][15:0], lfsr[20]);
                bus(1'b0, legacy_decode_pkg::STATUS_ADDR, 32'h0, 4'hF, q);
                check("status", q, {23'h0, (|(eh & map_m)) | lfsr[20], 1'b0, eh});
            end
        end
        // Mid-run reset must clear registers that were set
        bus(1'b1, legacy_decode_pkg::ENABLES_ADDR, 32'h0000_007F, 4'hF, q);
        bus(1'b1, legacy_decode_pkg::MAP_ADDR, 32'h0000_007F, 4'hF, q);
        @(posedge MCLK);
        RSTN <= 1'b0;
        repeat (3) @(posedge MCLK);
        check("wait_rst", {31'h0, AVS_WAITREQUEST}, 32'h0000_0001);
        check("claim_rst", {31'h0, IO_CLAIM}, 32'h0000_0000);
        RSTN <= 1'b1;
        bus(1'b0, legacy_decode_pkg::ENABLES_ADDR, 32'h0, 4'hF, q);
        check("enables_rerst", q, 32'h0000_0000);
        bus(1'b0, legacy_decode_pkg::MAP_ADDR, 32'h0, 4'hF, q);
        check("map_rerst", q, 32'h0000_0000);
        complete_run();
    end
endmodule : test_legacy_io_port_positive_decode
